//--- pkg/wdt_consts.svh
// Constants of the 16-bit supervision timer: offsets, resets, widths.
// Assumes inclusion by bare name from packages and modules alike.
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// ==========================================================
// Register offsets (byte addresses on the 32-bit register port)
`define WDT_OFS_LOAD      8'h60
`define WDT_OFS_VALUE     8'h64
`define WDT_OFS_CTRL      8'h68
`define WDT_OFS_CLEAR     8'h6C
`define WDT_OFS_CAPTURE   8'h70

// ==========================================================
// Widths
`define WDT_ADDR_W        8
`define WDT_DATA_W        32
`define WDT_CNT_W         16
`define WDT_CTRL_W        9
`define WDT_LFSR_W        8
`define WDT_PRE_W         8

// ==========================================================
// Reset values and fixed patterns
`define WDT_LOAD_RST      16'h03D7
`define WDT_CTRL_RST      9'h000
`define WDT_CNT_ZERO      16'h0000
`define WDT_CNT_ONE       16'h0001
`define WDT_CNT_FULL      16'hFFFF
`define WDT_LFSR_RST      8'h00
`define WDT_LFSR_TAPS     8'h63
`define WDT_CTRL_PAD      23'h000000
`define WDT_CNT_PAD       16'h0000
`define WDT_RDATA_ZERO    32'h00000000

// ==========================================================
// Prescaler selections and terminal counts
`define WDT_DIV_1         2'h0
`define WDT_DIV_16        2'h1
`define WDT_DIV_256       2'h2
`define WDT_PRE_TC_1      8'h00
`define WDT_PRE_TC_16     8'h0F
`define WDT_PRE_TC_256    8'hFF
`define WDT_PRE_ZERO      8'h00
`define WDT_PRE_ONE       8'h01

// Longest watchdog timeout in seconds, divide-by-256 and full load
`define WDT_MAX_TIMEOUT_S 512

`endif

//--- pkg/wdt_pkg.sv
// Types shared by the supervision timer modules.
// Assumes wdt_consts.svh on the include path.
`include "wdt_consts.svh"

package wdt_pkg;

    // ==========================================================
    // Control register fields, bit 8 down to bit 0
    typedef struct packed {
        logic       count_up;
        logic       enable;
        logic       periodic;
        logic       wdt_mode;
        logic       secure;
        logic [1:0] prescale;
        logic       irq_sel;
        logic       powerdown_halt;
    } watchdog_control_t;

    // ==========================================================
    // Register port request
    typedef struct packed {
        logic [`WDT_ADDR_W-1:0] addr;
        logic [`WDT_DATA_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } reg_req_t;

endpackage

//--- rtl/osc_prescaler.sv
// Oscillator pin synchroniser, debug-halt synchroniser and prescaler.
// Assumes a free-running 32.768 kHz square wave on osc_pin, far slower than clk_sys.
`timescale 1ns/100ps

module osc_prescaler
    import wdt_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic       ce,
    // Asynchronous pins
    input  wire logic       osc_pin,
    input  wire logic       jtag_halt_pin,
    // Control
    input  wire logic       hold,
    input  wire logic [1:0] div_sel,
    // Results
    output logic            jtag_halt,
    output logic            tick
);
    import wdt_pkg::*;

    // ==========================================================
    // Three-stage synchronisers, one per pin
    logic [1:0] pin_in;
    logic [1:0] s1_ff;
    logic [1:0] s2_ff;
    logic [1:0] s3_ff;
    logic [1:0] lvl_ff;
    logic       osc_prev_ff;
    logic [`WDT_PRE_W-1:0] pre_ff;
    logic [`WDT_PRE_W-1:0] pre_tc;
    logic       osc_rise;

    assign pin_in = {jtag_halt_pin, osc_pin};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
            // A level change counts only once stages two and three agree
            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    s1_ff[gi]  <= 1'b0;
                    s2_ff[gi]  <= 1'b0;
                    s3_ff[gi]  <= 1'b0;
                    lvl_ff[gi] <= 1'b0;
                end else if (ce) begin
                    s1_ff[gi] <= pin_in[gi];
                    s2_ff[gi] <= s1_ff[gi];
                    s3_ff[gi] <= s2_ff[gi];
                    if (s2_ff[gi] == s3_ff[gi]) begin
                        lvl_ff[gi] <= s3_ff[gi];
                    end
                end
            end
        end
    endgenerate

    assign jtag_halt = lvl_ff[1];

    // ==========================================================
    // Prescaler on oscillator rising edges
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            osc_prev_ff <= 1'b0;
        end else if (ce) begin
            osc_prev_ff <= lvl_ff[0];
        end
    end

    assign osc_rise = lvl_ff[0] & ~osc_prev_ff;

    always_comb begin
        case (div_sel)
            `WDT_DIV_1:   pre_tc = `WDT_PRE_TC_1;
            `WDT_DIV_16:  pre_tc = `WDT_PRE_TC_16;
            default:      pre_tc = `WDT_PRE_TC_256;
        endcase
    end

    // Held prescaler keeps its phase so a halted count resumes cleanly
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pre_ff <= `WDT_PRE_ZERO;
        end else if (ce && osc_rise && !hold) begin
            pre_ff <= (pre_ff >= pre_tc) ? `WDT_PRE_ZERO : pre_ff + `WDT_PRE_ONE;
        end
    end

    assign tick = ce & osc_rise & ~hold & (pre_ff >= pre_tc);

endmodule

//--- rtl/watchdog_timer_16bit.sv
// 16-bit supervision timer: normal counter or protected watchdog.
// Assumes srst is the power-on reset; other system resets arrive on soft_rst.
//
// Contract
// - Control register selects normal counting mode or watchdog mode.
// - Counter reloads from load register on overflow with periodic bit 6 set, and after an accepted clear write.
// - Normal mode is a 16-bit counter on 32.768 kHz divided 1, 16 or 256.
// - Capture count value on an event only when interrupt enable bit set.
// - Setting control bit 5 enters watchdog mode.
// - Watchdog mode counts down from the load value to zero.
// - Longest timeout 512 s with divide-by-256 and full-scale load.
// - Expiry at zero raises reset or interrupt, chosen by control bit 1.
// - Writing any value to clear reloads counter and starts a new period, except a mismatch under secure clear.
// - Watchdog mode write-protects load and control registers.
// - Only power-on reset clears protection and watchdog configuration.
// - Other resets leave the watchdog counting.
// - Counter halts while the debugger holds the processor.
// - Counter runs in power-down unless control bit 0 is set.
// - Interrupt-select set gives interrupt at expiry, clear gives reset.
// - Load register is 16 bits and resets to 0x03D7.
// - Secure clear compares writes with an 8-bit LFSR seeded before entry.
// - Matching write advances LFSR at reload; mismatch resets immediately.
`timescale 1ns/100ps

module watchdog_timer_16bit
    import wdt_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                   clk_sys,
    input  wire logic                   srst,
    input  wire logic                   ce,
    input  wire logic                   soft_rst,
    // Register port
    input  wire wdt_pkg::reg_req_t      reg_req,
    output logic [`WDT_DATA_W-1:0]      reg_rdata,
    // Pins from outside the clock domain
    input  wire logic                   osc_pin,
    input  wire logic                   jtag_halt_pin,
    // System status on clk_sys
    input  wire logic                   pd_active,
    input  wire logic                   capture_event,
    input  wire logic                   capture_irq_en,
    // Watchdog results
    output logic                        wdt_reset,
    output logic                        wdt_irq
);
    import wdt_pkg::*;

    // ==========================================================
    // State
    watchdog_control_t            ctrl_ff;
    logic [`WDT_CNT_W-1:0]        load_ff;
    logic [`WDT_CNT_W-1:0]        count_ff;
    logic [`WDT_CNT_W-1:0]        nxt_count;
    logic [`WDT_CNT_W-1:0]        cap_ff;
    logic [`WDT_LFSR_W-1:0]       lfsr_ff;
    logic [`WDT_LFSR_W-1:0]       nxt_lfsr;
    logic [`WDT_DATA_W-1:0]       rdata_ff;
    logic                         rst_ff;
    logic                         irq_ff;

    // ==========================================================
    // Decode
    logic wr_load;
    logic wr_ctrl;
    logic svc_wr;
    logic secure_act;
    logic svc_bad;
    logic svc_ok;
    logic halt;
    logic jtag_halt;
    logic tick;
    logic step;
    logic expire;
    logic ovf;

    assign wr_load    = reg_req.wr && (reg_req.addr == `WDT_OFS_LOAD);
    assign wr_ctrl    = reg_req.wr && (reg_req.addr == `WDT_OFS_CTRL);
    assign svc_wr     = ce && reg_req.wr && (reg_req.addr == `WDT_OFS_CLEAR);
    assign secure_act = ctrl_ff.wdt_mode & ctrl_ff.secure;
    // Zero never matches, so under a zero seed every clear write ends in a reset
    assign svc_bad    = svc_wr && secure_act &&
                        ((reg_req.wdata[`WDT_LFSR_W-1:0] != lfsr_ff) ||
                         (reg_req.wdata[`WDT_LFSR_W-1:0] == `WDT_LFSR_RST));
    assign svc_ok     = svc_wr && !svc_bad;

    // Debug hold and optional power-down stop freeze the count
    assign halt = jtag_halt | (pd_active & ctrl_ff.powerdown_halt);

    osc_prescaler u_osc_prescaler (
        .clk_sys       (clk_sys),
        .srst          (srst),
        .ce            (ce),
        .osc_pin       (osc_pin),
        .jtag_halt_pin (jtag_halt_pin),
        .hold          (halt),
        .div_sel       (ctrl_ff.prescale),
        .jtag_halt     (jtag_halt),
        .tick          (tick)
    );

    // Watchdog mode runs regardless of the enable bit
    assign step   = tick & (ctrl_ff.wdt_mode | ctrl_ff.enable);
    assign expire = step & ctrl_ff.wdt_mode & (count_ff == `WDT_CNT_ZERO);
    assign ovf    = step & ~ctrl_ff.wdt_mode &
                    (ctrl_ff.count_up ? (count_ff == `WDT_CNT_FULL) : (count_ff == `WDT_CNT_ZERO));

    // ==========================================================
    // Control and load registers; only the power-on reset unlocks
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctrl_ff <= `WDT_CTRL_RST;
        end else if (ce && wr_ctrl && !ctrl_ff.wdt_mode) begin
            ctrl_ff <= reg_req.wdata[`WDT_CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            load_ff <= `WDT_LOAD_RST;
        end else if (ce && wr_load && !ctrl_ff.wdt_mode) begin
            load_ff <= reg_req.wdata[`WDT_CNT_W-1:0];
        end
    end

    // ==========================================================
    // Counter; soft_rst deliberately has no effect here
    always_comb begin
        nxt_count = count_ff;
        if (svc_ok) begin
            nxt_count = load_ff;
        end else if (step) begin
            if (ctrl_ff.wdt_mode) begin
                nxt_count = expire ? load_ff : count_ff - `WDT_CNT_ONE;
            end else if (ovf && ctrl_ff.periodic) begin
                nxt_count = load_ff;
            end else if (ctrl_ff.count_up) begin
                nxt_count = count_ff + `WDT_CNT_ONE;
            end else begin
                nxt_count = count_ff - `WDT_CNT_ONE;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            count_ff <= `WDT_LOAD_RST;
        end else if (ce) begin
            count_ff <= nxt_count;
        end
    end

    // ==========================================================
    // Secure-clear LFSR, Galois form of x8+x6+x5+x+1
    assign nxt_lfsr = {lfsr_ff[`WDT_LFSR_W-2:0], 1'b0} ^ (lfsr_ff[`WDT_LFSR_W-1] ? `WDT_LFSR_TAPS : `WDT_LFSR_RST);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lfsr_ff <= `WDT_LFSR_RST;
        end else if (svc_wr && !ctrl_ff.wdt_mode) begin
            lfsr_ff <= reg_req.wdata[`WDT_LFSR_W-1:0];
        end else if (svc_ok && secure_act) begin
            lfsr_ff <= nxt_lfsr;
        end
    end

    // ==========================================================
    // Capture in normal mode
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cap_ff <= `WDT_CNT_ZERO;
        end else if (ce && capture_event && capture_irq_en && !ctrl_ff.wdt_mode) begin
            cap_ff <= count_ff;
        end
    end

    // ==========================================================
    // Reset pulse and interrupt flag; a new event beats a same-cycle clear
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rst_ff <= 1'b0;
        end else if (ce) begin
            rst_ff <= (expire & ~ctrl_ff.irq_sel) | svc_bad;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq_ff <= 1'b0;
        end else if (ce) begin
            irq_ff <= (expire & ctrl_ff.irq_sel) | ovf | (irq_ff & ~svc_wr & ~soft_rst);
        end
    end

    assign wdt_reset = rst_ff;
    assign wdt_irq   = irq_ff;

    // ==========================================================
    // Read port: data only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rdata_ff <= `WDT_RDATA_ZERO;
        end else if (ce) begin
            rdata_ff <= `WDT_RDATA_ZERO;
            if (reg_req.rd) begin
                case (reg_req.addr)
                    `WDT_OFS_LOAD:    rdata_ff <= {`WDT_CNT_PAD, load_ff};
                    `WDT_OFS_VALUE:   rdata_ff <= {`WDT_CNT_PAD, count_ff};
                    `WDT_OFS_CTRL:    rdata_ff <= {`WDT_CTRL_PAD, ctrl_ff};
                    `WDT_OFS_CAPTURE: rdata_ff <= {`WDT_CNT_PAD, cap_ff};
                    default:          rdata_ff <= `WDT_RDATA_ZERO;
                endcase
            end
        end
    end

    assign reg_rdata = rdata_ff;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    a_load_locked: assert property (ce && ctrl_ff.wdt_mode && wr_load |=> $stable(load_ff))
        else $error("load changed while locked");
    a_ctrl_locked: assert property (ce && ctrl_ff.wdt_mode |=> ctrl_ff == $past(ctrl_ff))
        else $error("control changed while locked");
    a_mode_entry: assert property (ce && wr_ctrl && !ctrl_ff.wdt_mode && reg_req.wdata[5]
                                   |=> ctrl_ff.wdt_mode)
        else $error("watchdog mode not entered");
    a_mode_sticky: assert property (ctrl_ff.wdt_mode |=> ctrl_ff.wdt_mode[*3])
        else $error("watchdog mode left without power-on reset");
    a_service_reload: assert property (svc_ok |=> count_ff == $past(load_ff))
        else $error("service write did not reload");
    a_count_down: assert property (ce && step && ctrl_ff.wdt_mode && !svc_ok && count_ff != `WDT_CNT_ZERO
                                   |=> count_ff == $past(count_ff) - `WDT_CNT_ONE)
        else $error("watchdog count did not decrement");
    a_expire_reset: assert property (ce && expire && !ctrl_ff.irq_sel |=> wdt_reset ##1 !wdt_reset || expire)
        else $error("expiry reset pulse wrong");
    a_expire_irq: assert property (ce && expire && ctrl_ff.irq_sel |=> wdt_irq && !wdt_reset)
        else $error("expiry interrupt missing");
    a_secure_bad: assert property (ce && svc_bad |=> wdt_reset)
        else $error("secure mismatch did not reset");
    a_halt_freeze: assert property (ce && jtag_halt && !svc_ok |=> $stable(count_ff))
        else $error("count moved under debug halt");
    a_pd_freeze: assert property (ce && pd_active && ctrl_ff.powerdown_halt && !svc_ok
                                  |=> $stable(count_ff))
        else $error("count moved in power-down stop");
    a_capture_gate: assert property (ce && capture_event && !capture_irq_en |=> $stable(cap_ff))
        else $error("capture without enable");
    a_periodic_reload: assert property (ce && ovf && ctrl_ff.periodic && !svc_ok
                                        |=> count_ff == $past(load_ff))
        else $error("periodic overflow did not reload");

    c_watchdog_expire: cover property (ce && expire && !ctrl_ff.irq_sel);
    c_secure_advance: cover property (svc_ok && secure_act);
    c_capture: cover property (ce && capture_event && capture_irq_en && !ctrl_ff.wdt_mode);
    c_locked_write: cover property (ce && ctrl_ff.wdt_mode && wr_load);

endmodule

//--- dv/testbench.sv
// Self-checking bench for the 16-bit supervision timer.
// Assumes wdt_pkg is compiled first; the oscillator pin is made here, 32 clocks a period.
`timescale 1ns/100ps
`include "wdt_consts.svh"

module testbench;
    import wdt_pkg::*;

    // ==========================================================
    // Signals
    logic        clk_sys        = 1'b0;
    logic        srst           = 1'b1;
    logic        soft_rst       = 1'b0;
    logic        ce             = 1'b1;
    reg_req_t    reg_req        = '0;
    logic [31:0] reg_rdata;
    logic        osc_pin        = 1'b0;
    logic        jtag_halt_pin  = 1'b0;
    logic        pd_active      = 1'b0;
    logic        capture_event  = 1'b0;
    logic        capture_irq_en = 1'b0;
    logic        wdt_reset;
    logic        wdt_irq;
    logic [4:0]  osc_div        = 5'h00;
    int          err_total      = 0;
    int          n_checks       = 0;
    int          rst_pulses     = 0;
    int          cycles         = 0;
    int          base;

    watchdog_timer_16bit u_watchdog_timer_16bit (
        .clk_sys       (clk_sys),
        .srst          (srst),
        .ce            (ce),
        .soft_rst      (soft_rst),
        .reg_req       (reg_req),
        .reg_rdata     (reg_rdata),
        .osc_pin       (osc_pin),
        .jtag_halt_pin (jtag_halt_pin),
        .pd_active     (pd_active),
        .capture_event (capture_event),
        .capture_irq_en(capture_irq_en),
        .wdt_reset     (wdt_reset),
        .wdt_irq       (wdt_irq)
    );

    always #2 clk_sys = ~clk_sys;

    // Fast oscillator keeps the run short; still far slower than clk_sys
    always @(posedge clk_sys) begin
        osc_div <= osc_div + 5'h01;
        osc_pin <= osc_div[4];
        cycles++;
        if (wdt_reset === 1'b1) begin
            rst_pulses++;
        end
        if (cycles == 12000) begin
            err_total++;
            conclude();
        end
    end

    // ==========================================================
    // Helpers
    task automatic conclude();
        if (err_total == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_req.addr  <= a;
        reg_req.wdata <= d;
        reg_req.wr    <= 1'b1;
        @(posedge clk_sys);
        reg_req.wr    <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_req.addr <= a;
        reg_req.rd   <= 1'b1;
        @(posedge clk_sys);
        reg_req.rd   <= 1'b0;
        #1;
        chk32(reg_rdata, exp);
    endtask

    // Ends ten clocks after the n-th oscillator rise, clear of any tick
    task automatic edges(input int n);
        repeat (n) @(posedge osc_pin);
        repeat (10) @(posedge clk_sys);
    endtask

    task automatic por();
        @(posedge clk_sys);
        srst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask

    task automatic cap_pulse(input logic en);
        @(posedge clk_sys);
        capture_irq_en <= en;
        capture_event  <= 1'b1;
        @(posedge clk_sys);
        capture_event  <= 1'b0;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_reset_vals();
        reg_chk(`WDT_OFS_LOAD, 32'h000003D7);
        reg_chk(`WDT_OFS_VALUE, 32'h000003D7);
        reg_chk(`WDT_OFS_CTRL, 32'h00000000);
        reg_chk(`WDT_OFS_CAPTURE, 32'h00000000);
        reg_chk(`WDT_OFS_CLEAR, 32'h00000000);
        reg_chk(8'h7C, 32'h00000000);
    endtask

    task automatic t_capture();
        reg_wr(`WDT_OFS_LOAD, 32'h00001234);
        reg_wr(`WDT_OFS_CLEAR, 32'h00000000);
        reg_chk(`WDT_OFS_VALUE, 32'h00001234);
        cap_pulse(1'b0);
        reg_chk(`WDT_OFS_CAPTURE, 32'h00000000);
        cap_pulse(1'b1);
        reg_chk(`WDT_OFS_CAPTURE, 32'h00001234);
    endtask

    task automatic t_normal();
        reg_wr(`WDT_OFS_LOAD, 32'h00000100);
        reg_wr(`WDT_OFS_CTRL, 32'h00000080);
        edges(1);
        reg_wr(`WDT_OFS_CLEAR, 32'h00000000);
        edges(3);
        reg_chk(`WDT_OFS_VALUE, 32'h000000FD);
        reg_wr(`WDT_OFS_CTRL, 32'h00000180);
        reg_wr(`WDT_OFS_CLEAR, 32'h00000000);
        edges(3);
        reg_chk(`WDT_OFS_VALUE, 32'h00000103);
        reg_wr(`WDT_OFS_CTRL, 32'h00000080);
        reg_wr(`WDT_OFS_CLEAR, 32'h00000000);
        jtag_halt_pin <= 1'b1;
        edges(3);
        reg_chk(`WDT_OFS_VALUE, 32'h00000100);
        jtag_halt_pin <= 1'b0;
        edges(2);
        reg_chk(`WDT_OFS_VALUE, 32'h000000FE);
        // Clock enable low freezes count, prescaler and synchronisers
        @(posedge clk_sys);
        ce <= 1'b0;
        edges(2);
        ce <= 1'b1;
        reg_chk(`WDT_OFS_VALUE, 32'h000000FE);
        @(posedge clk_sys);
        pd_active <= 1'b1;
        reg_wr(`WDT_OFS_CLEAR, 32'h00000000);
        edges(2);
        reg_chk(`WDT_OFS_VALUE, 32'h000000FE);
        reg_wr(`WDT_OFS_CTRL, 32'h00000081);
        reg_wr(`WDT_OFS_CLEAR, 32'h00000000);
        edges(2);
        reg_chk(`WDT_OFS_VALUE, 32'h00000100);
        pd_active <= 1'b0;
    endtask

    task automatic t_wrap();
        reg_wr(`WDT_OFS_LOAD, 32'h00000002);
        reg_wr(`WDT_OFS_CTRL, 32'h000000C0);
        reg_wr(`WDT_OFS_CLEAR, 32'h00000000);
        edges(3);
        reg_chk(`WDT_OFS_VALUE, 32'h00000002);
        chk1(wdt_irq, 1'b1);
        reg_wr(`WDT_OFS_CLEAR, 32'h00000000);
        chk1(wdt_irq, 1'b0);
        reg_wr(`WDT_OFS_CTRL, 32'h00000080);
        reg_wr(`WDT_OFS_CLEAR, 32'h00000000);
        edges(3);
        reg_chk(`WDT_OFS_VALUE, 32'h0000FFFF);
        // Prescaler phase is not cleared, so exactly one tick in 16 rises
        reg_wr(`WDT_OFS_CTRL, 32'h00000084);
        reg_wr(`WDT_OFS_CLEAR, 32'h00000000);
        edges(16);
        reg_chk(`WDT_OFS_VALUE, 32'h00000001);
    endtask

    task automatic t_wdt_irq();
        reg_wr(`WDT_OFS_LOAD, 32'h00000003);
        edges(1);
        reg_wr(`WDT_OFS_CLEAR, 32'h00000000);
        reg_wr(`WDT_OFS_CTRL, 32'h00000022);
        reg_wr(`WDT_OFS_LOAD, 32'h00000055);
        reg_wr(`WDT_OFS_CTRL, 32'h00000000);
        reg_chk(`WDT_OFS_LOAD, 32'h00000003);
        reg_chk(`WDT_OFS_CTRL, 32'h00000022);
        edges(2);
        reg_chk(`WDT_OFS_VALUE, 32'h00000001);
        @(posedge clk_sys);
        soft_rst <= 1'b1;
        @(posedge clk_sys);
        soft_rst <= 1'b0;
        edges(1);
        reg_chk(`WDT_OFS_VALUE, 32'h00000000);
        reg_chk(`WDT_OFS_CTRL, 32'h00000022);
        chk1(wdt_irq, 1'b0);
        edges(1);
        chk1(wdt_irq, 1'b1);
        reg_chk(`WDT_OFS_VALUE, 32'h00000003);
        reg_wr(`WDT_OFS_CLEAR, 32'h0000005A);
        chk1(wdt_irq, 1'b0);
        edges(2);
        reg_wr(`WDT_OFS_CLEAR, 32'h00000000);
        edges(2);
        reg_chk(`WDT_OFS_VALUE, 32'h00000001);
        chk32(rst_pulses, 32'h00000000);
    endtask

    task automatic t_wdt_reset();
        reg_chk(`WDT_OFS_CTRL, 32'h00000000);
        reg_chk(`WDT_OFS_LOAD, 32'h000003D7);
        reg_wr(`WDT_OFS_LOAD, 32'h00000001);
        edges(1);
        reg_wr(`WDT_OFS_CLEAR, 32'h00000000);
        reg_wr(`WDT_OFS_CTRL, 32'h00000020);
        base = rst_pulses;
        edges(1);
        chk32(rst_pulses - base, 32'h00000000);
        edges(1);
        chk32(rst_pulses - base, 32'h00000001);
        chk1(wdt_irq, 1'b0);
    endtask

    task automatic t_secure();
        logic [7:0] seq [3];
        seq = '{8'hAA, 8'h37, 8'h6E};
        reg_wr(`WDT_OFS_LOAD, 32'h00000020);
        reg_wr(`WDT_OFS_CLEAR, 32'h000000AA);
        reg_wr(`WDT_OFS_CTRL, 32'h00000030);
        base = rst_pulses;
        foreach (seq[i]) begin
            edges(1);
            reg_wr(`WDT_OFS_CLEAR, {24'h000000, seq[i]});
            reg_chk(`WDT_OFS_VALUE, 32'h00000020);
        end
        chk32(rst_pulses - base, 32'h00000000);
        edges(1);
        reg_wr(`WDT_OFS_CLEAR, 32'h00000066);
        @(posedge clk_sys);
        #1;
        chk32(rst_pulses - base, 32'h00000001);
        reg_chk(`WDT_OFS_VALUE, 32'h0000001F);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        por();
        t_reset_vals();
        t_capture();
        t_normal();
        t_wrap();
        por();
        t_wdt_irq();
        por();
        t_wdt_reset();
        por();
        t_secure();
        conclude();
    end

endmodule
